//--- lcsr_pkg.sv
// Purpose: constants and carrier types for the led current setting bank
// Assumes: 8-bit register port driven by the serial control decoder
// Notes: current codes step 12.5 mA; torch tops at 200 mA, flash at 750 mA
package lcsr_pkg;
    // register offsets
    localparam logic [7:0] LCSR_OFF_LED1_TORCH = 8'h08;
    localparam logic [7:0] LCSR_OFF_LED2_FLASH = 8'h09;
    localparam logic [7:0] LCSR_OFF_LED2_MASK = 8'h0A;
    localparam logic [7:0] LCSR_OFF_LED2_TORCH = 8'h0B;
    // field layout
    localparam int LCSR_TORCH_W = 5;
    localparam int LCSR_FLASH_W = 6;
    // reset values: 50 mA, 500 mA, 250 mA, 50 mA
    localparam logic [7:0] LCSR_RST_LED1_TORCH = 8'h04;
    localparam logic [7:0] LCSR_RST_LED2_FLASH = 8'h28;
    localparam logic [7:0] LCSR_RST_LED2_MASK = 8'h14;
    localparam logic [7:0] LCSR_RST_LED2_TORCH = 8'h04;
    // saturation codes: 200 mA and 750 mA
    localparam logic [4:0] LCSR_TORCH_MAX = 5'h10;
    localparam logic [5:0] LCSR_FLASH_MAX = 6'h3C;
    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } lcsr_req_t;
endpackage

//--- lcsr_regs.sv
// Purpose: led current setting registers with saturated current codes
// Assumes: requests are synchronous to sys_clk, one per cycle at most
// Notes: codes and read data are registered, one cycle behind the store
//
// Contract
// - first led torch code, 12.5 mA, 200 cap
// - second led torch code, same step and cap
// - second led flash code, 750 cap, 500 default
// - second led mask code, 750 cap, 250 default
`timescale 1ns/1ps
module lcsr_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire lcsr_pkg::lcsr_req_t req,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // analog side
    input wire logic transmit_mask_input,
    output logic [4:0] first_led_torch_code,
    output logic [4:0] second_led_torch_code,
    output logic [5:0] second_led_flash_code,
    output logic [5:0] second_led_mask_code,
    output logic [5:0] second_led_drive_code
);

    ////////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] led1_torch_current_setting;
    logic [7:0] led2_flash_current_setting;
    logic [7:0] led2_mask_current_setting;
    logic [7:0] led2_torch_current_setting;
    logic [7:0] next_led1_torch;
    logic [7:0] next_led2_flash;
    logic [7:0] next_led2_mask;
    logic [7:0] next_led2_torch;
    logic [7:0] next_rd_data;
    logic next_rd_valid;
    logic [4:0] next_t1;
    logic [4:0] next_t2;
    logic [5:0] next_fl;
    logic [5:0] next_mk;
    logic [5:0] next_drive;

    // saturate a torch code at the 200 mA point
    function automatic logic [4:0] sat_torch(input logic [4:0] c);
        sat_torch = (c > lcsr_pkg::LCSR_TORCH_MAX) ?
            lcsr_pkg::LCSR_TORCH_MAX : c;
    endfunction

    // saturate a flash or mask code at the 750 mA point
    function automatic logic [5:0] sat_flash(input logic [5:0] c);
        sat_flash = (c > lcsr_pkg::LCSR_FLASH_MAX) ?
            lcsr_pkg::LCSR_FLASH_MAX : c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // write decode, whole byte kept including reserved bits
    always_comb begin
        next_led1_torch = led1_torch_current_setting;
        next_led2_flash = led2_flash_current_setting;
        next_led2_mask = led2_mask_current_setting;
        next_led2_torch = led2_torch_current_setting;
        if (req.wr && req.addr == lcsr_pkg::LCSR_OFF_LED1_TORCH) begin
            next_led1_torch = req.data;
        end else if (req.wr && req.addr == lcsr_pkg::LCSR_OFF_LED2_FLASH) begin
            next_led2_flash = req.data;
        end else if (req.wr && req.addr == lcsr_pkg::LCSR_OFF_LED2_MASK) begin
            next_led2_mask = req.data;
        end else if (req.wr && req.addr == lcsr_pkg::LCSR_OFF_LED2_TORCH) begin
            next_led2_torch = req.data;
        end
    end

    // register store, defaults on reset
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            led1_torch_current_setting <= lcsr_pkg::LCSR_RST_LED1_TORCH;
            led2_flash_current_setting <= lcsr_pkg::LCSR_RST_LED2_FLASH;
            led2_mask_current_setting <= lcsr_pkg::LCSR_RST_LED2_MASK;
            led2_torch_current_setting <= lcsr_pkg::LCSR_RST_LED2_TORCH;
        end else begin
            led1_torch_current_setting <= next_led1_torch;
            led2_flash_current_setting <= next_led2_flash;
            led2_mask_current_setting <= next_led2_mask;
            led2_torch_current_setting <= next_led2_torch;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode, unmapped offsets read as zero
    always_comb begin
        next_rd_valid = req.rd;
        next_rd_data = 8'h00;
        if (req.rd && req.addr == lcsr_pkg::LCSR_OFF_LED1_TORCH) begin
            next_rd_data = led1_torch_current_setting;
        end else if (req.rd && req.addr == lcsr_pkg::LCSR_OFF_LED2_FLASH) begin
            next_rd_data = led2_flash_current_setting;
        end else if (req.rd && req.addr == lcsr_pkg::LCSR_OFF_LED2_MASK) begin
            next_rd_data = led2_mask_current_setting;
        end else if (req.rd && req.addr == lcsr_pkg::LCSR_OFF_LED2_TORCH) begin
            next_rd_data = led2_torch_current_setting;
        end
    end

    // read answer register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // current codes from the low field only, saturated
    always_comb begin
        next_t1 = sat_torch(led1_torch_current_setting[4:0]);
        next_t2 = sat_torch(led2_torch_current_setting[4:0]);
        next_fl = sat_flash(led2_flash_current_setting[5:0]);
        next_mk = sat_flash(led2_mask_current_setting[5:0]);
        next_drive = transmit_mask_input ? next_mk : next_fl;
    end

    // code output register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            first_led_torch_code <= lcsr_pkg::LCSR_RST_LED1_TORCH[4:0];
            second_led_torch_code <= lcsr_pkg::LCSR_RST_LED2_TORCH[4:0];
            second_led_flash_code <= lcsr_pkg::LCSR_RST_LED2_FLASH[5:0];
            second_led_mask_code <= lcsr_pkg::LCSR_RST_LED2_MASK[5:0];
            second_led_drive_code <= lcsr_pkg::LCSR_RST_LED2_FLASH[5:0];
        end else begin
            first_led_torch_code <= next_t1;
            second_led_torch_code <= next_t2;
            second_led_flash_code <= next_fl;
            second_led_mask_code <= next_mk;
            second_led_drive_code <= next_drive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_wr_t1;
        req.wr && req.addr == lcsr_pkg::LCSR_OFF_LED1_TORCH;
    endsequence

    sequence s_rd_t1;
        req.rd && req.addr == lcsr_pkg::LCSR_OFF_LED1_TORCH && !req.wr;
    endsequence

    sequence s_wr_t2;
        req.wr && req.addr == lcsr_pkg::LCSR_OFF_LED2_TORCH;
    endsequence

    sequence s_wr_fl;
        req.wr && req.addr == lcsr_pkg::LCSR_OFF_LED2_FLASH;
    endsequence

    sequence s_wr_mk;
        req.wr && req.addr == lcsr_pkg::LCSR_OFF_LED2_MASK;
    endsequence

    property p_t2_store;
        @(posedge sys_clk) disable iff (!resetn)
        s_wr_t2 |=> led2_torch_current_setting == $past(req.data);
    endproperty
    a_t2_store: assert property (p_t2_store)
        else $error("second torch register did not take write");

    property p_fl_store;
        @(posedge sys_clk) disable iff (!resetn)
        s_wr_fl |=> led2_flash_current_setting == $past(req.data);
    endproperty
    a_fl_store: assert property (p_fl_store)
        else $error("flash register did not take write");

    property p_mk_store;
        @(posedge sys_clk) disable iff (!resetn)
        s_wr_mk |=> led2_mask_current_setting == $past(req.data);
    endproperty
    a_mk_store: assert property (p_mk_store)
        else $error("mask register did not take write");

    property p_t1_store;
        @(posedge sys_clk) disable iff (!resetn)
        s_wr_t1 |=> led1_torch_current_setting == $past(req.data);
    endproperty
    a_t1_store: assert property (p_t1_store)
        else $error("first torch register did not take write");

    property p_t1_code;
        @(posedge sys_clk) disable iff (!resetn)
        s_wr_t1 |-> ##2 first_led_torch_code ==
            (($past(req.data[4:0], 2) > lcsr_pkg::LCSR_TORCH_MAX) ?
            lcsr_pkg::LCSR_TORCH_MAX : $past(req.data[4:0], 2));
    endproperty
    a_t1_code: assert property (p_t1_code)
        else $error("first torch code not saturated at 16");

    property p_t2_code;
        @(posedge sys_clk) disable iff (!resetn)
        second_led_torch_code ==
            (($past(led2_torch_current_setting[4:0]) >
            lcsr_pkg::LCSR_TORCH_MAX) ? lcsr_pkg::LCSR_TORCH_MAX :
            $past(led2_torch_current_setting[4:0]));
    endproperty
    a_t2_code: assert property (p_t2_code)
        else $error("second torch code out of range");

    property p_fl_code;
        @(posedge sys_clk) disable iff (!resetn)
        ($past(led2_flash_current_setting[5:0]) >
            lcsr_pkg::LCSR_FLASH_MAX) ?
        second_led_flash_code == lcsr_pkg::LCSR_FLASH_MAX :
        second_led_flash_code == $past(led2_flash_current_setting[5:0]);
    endproperty
    a_fl_code: assert property (p_fl_code)
        else $error("flash code not saturated at 60");

    property p_mk_select;
        @(posedge sys_clk) disable iff (!resetn)
        // drive is forced to the flash default while reset is low
        $past(resetn) |->
        second_led_mask_code <= lcsr_pkg::LCSR_FLASH_MAX &&
        (second_led_drive_code ==
        ($past(transmit_mask_input) ? second_led_mask_code :
        second_led_flash_code));
    endproperty
    a_mk_select: assert property (p_mk_select)
        else $error("drive code does not follow mask input");

    property p_rsv_ignored;
        @(posedge sys_clk) disable iff (!resetn)
        $stable(led1_torch_current_setting[4:0]) &&
        $stable(led2_flash_current_setting[5:0]) |=>
        $stable(first_led_torch_code) && $stable(second_led_flash_code);
    endproperty
    a_rsv_ignored: assert property (p_rsv_ignored)
        else $error("reserved bits changed a current code");

    property p_rsv_readback;
        @(posedge sys_clk) disable iff (!resetn)
        s_rd_t1 |=> rd_valid && rd_data == $past(led1_torch_current_setting);
    endproperty
    a_rsv_readback: assert property (p_rsv_readback)
        else $error("first torch readback lost bits");

endmodule // lcsr_regs

//--- lcsr_host.sv
// Purpose: host model driving the register port
// Assumes: one request per call, driven 1 ns after a rising edge
// Notes: idle port shows inverted values so stale data is not reused
`timescale 1ns/1ps
module lcsr_host (
    // clock
    input wire logic sys_clk,
    // register port
    output lcsr_pkg::lcsr_req_t req,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    // one request held for exactly one taken edge
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic v);
        @(posedge sys_clk);
        #1 req = '{wr: w, rd: r, addr: a, data: d};
        @(posedge sys_clk);
        #1 q = rd_data;
        v = rd_valid;
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask
    initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, data: 8'h00};
endmodule // lcsr_host

//--- led_current_setting_regs_bench.sv
// Purpose: self-checking bench for the led current setting bank
// Assumes: host model drives the port 1 ns after each rising edge
// Notes: expectations come from a shadow copy of the four registers
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module led_current_setting_regs_bench;
    logic sys_clk, resetn, mask, v, r;
    logic [7:0] rd_data, q, a, d;
    logic rd_valid;
    logic [4:0] t1, t2;
    logic [5:0] fl, mk, dr;
    lcsr_pkg::lcsr_req_t req;
    logic [7:0] shadow [4];
    logic [7:0] corner [8] = '{8'h1F, 8'h10, 8'h11, 8'h0C, 8'h3C, 8'h3D,
        8'h3F, 8'hFF};
    logic [31:0] seed = 32'h00018364; // 99172
    int err_count = 0;
    int n_compared = 0;
    lcsr_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .req(req),
        .rd_data(rd_data), .rd_valid(rd_valid),
        .transmit_mask_input(mask), .first_led_torch_code(t1),
        .second_led_torch_code(t2), .second_led_flash_code(fl),
        .second_led_mask_code(mk), .second_led_drive_code(dr));
    lcsr_host u_host (.sys_clk(sys_clk), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // torch caps at 200 mA, flash and mask at 750 mA
    function automatic logic [4:0] sat5(input logic [7:0] x);
        return (x[4:0] > 5'h10) ? 5'h10 : x[4:0];
    endfunction
    function automatic logic [5:0] sat6(input logic [7:0] x);
        return (x[5:0] > 6'h3C) ? 6'h3C : x[5:0];
    endfunction
    function automatic logic [7:0] rexp(input logic [7:0] x);
        return (x inside {[8'h08:8'h0B]}) ? shadow[x[1:0]] : 8'h00;
    endfunction
    task automatic check_codes();
        `CHK(t1, sat5(shadow[0]))
        `CHK(t2, sat5(shadow[3]))
        `CHK(fl, sat6(shadow[1]))
        `CHK(mk, sat6(shadow[2]))
        `CHK(dr, mask ? sat6(shadow[2]) : sat6(shadow[1]))
    endtask
    // reset, then read back every default
    task automatic do_reset();
        resetn = 1'b0;
        shadow = '{8'h04, 8'h28, 8'h14, 8'h04};
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            u_host.acc(1'b0, 1'b1, 8'h08 + 8'(i), 8'h00, q, v);
            `CHK(q, shadow[i])
            `CHK(v, 1'b1)
        end
        check_codes();
    endtask
    task automatic conclude();
        if (err_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #(50 * 4000);
        err_count++;
        conclude();
    end
    // corner codes first, then random writes with optional same-cycle read
    initial begin
        mask = 1'b0;
        do_reset();
        for (int n = 0; n < 200; n++) begin
            seed = xs(seed);
            // corner codes go round the four mapped offsets in turn
            a = (n < 8) ? 8'h08 + 8'(n % 4) :
                8'h07 + 8'(seed[2:0] % 3'h6);
            d = (n < 8) ? corner[n] : seed[15:8];
            r = seed[20];
            mask = seed[21];
            u_host.acc(1'b1, r, a, d, q, v);
            `CHK(v, r)
            `CHK(q, r ? rexp(a) : 8'h00)
            if (a inside {[8'h08:8'h0B]}) shadow[a[1:0]] = d;
            u_host.acc(1'b0, 1'b1, a, 8'h00, q, v);
            `CHK(q, rexp(a))
            check_codes();
        end
        do_reset();
        conclude();
    end
endmodule // led_current_setting_regs_bench
